// file: hdl/dcc_pkg.sv
// package of constants and types for the dual comparator control block
package dcc_pkg;
  // ****************************************************************
  // register map (byte addresses on the wishbone bus)
  // ****************************************************************
  localparam logic [3:0] ADDR_CONTROL   = 4'h0;  // comparator_control
  localparam logic [3:0] ADDR_STATUS    = 4'h4;  // sticky event status
  localparam logic [3:0] ADDR_MASK      = 4'h8;  // interrupt mask
  localparam logic [3:0] ADDR_DIRECTION = 4'hC;  // porta_direction
  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int          BIT_CMP2_RESULT = 7;
  localparam int          BIT_CMP1_RESULT = 6;
  localparam int          BIT_CMP2_INVERT = 5;
  localparam int          BIT_CMP1_INVERT = 4;
  localparam int          BIT_INPUT_SWITCH = 3;
  localparam int          MODE_MSB        = 2;
  localparam logic [7:0]  CONTROL_RESET   = 8'h07;  // mode 111, rest clear
  localparam logic [2:0]  MODE_OFF        = 3'h7;   // both comparators off
  localparam logic [2:0]  MODE_MUX4       = 3'h6;   // four inputs, internal ref
  // ****************************************************************
  // status, mask and direction fields
  // ****************************************************************
  localparam int          BIT_CHANGE      = 0;  // cmp_change_flag
  localparam int          BIT_SETTLING    = 1;  // settle interval over
  localparam logic [1:0]  STATUS_RESET    = 2'h0;
  localparam logic [1:0]  MASK_RESET      = 2'h0;
  localparam logic [5:0]  DIRECTION_RESET = 6'h3F;  // all pins input
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_MHZ         = 125;
  localparam int          SETTLE_NS       = 10000;  // mode change delay
  localparam int          SETTLE_CYCLES   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  // settle state machine
  typedef enum logic [1:0] {
    DCC_IDLE   = 2'b00,
    DCC_SETTLE = 2'b01
  } dcc_settle_type;
endpackage : dcc_pkg

// file: hdl/dcc_sync_if.sv
// interface carrying raw and synchronised comparator outputs
`timescale 1ns/10ps
`default_nettype none
interface dcc_sync_if;
  logic [1:0] raw;   // asynchronous analog comparator outputs
  logic [1:0] sync;  // outputs in the clk_i domain
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface : dcc_sync_if
`default_nettype wire

// file: hdl/dcc_sync.sv
// two flop synchroniser for both comparator outputs
`timescale 1ns/10ps
`default_nettype none
module dcc_sync
(
  input  wire logic clk_i,  // system clock
  input  wire logic rst_i,  // synchronous reset
  dcc_sync_if.dst   sif     // raw in, synced out
);
  logic [1:0] meta_q;  // first stage, read only by second stage
  logic [1:0] sync_q;  // second stage
  // ****************************************************************
  // synchroniser flops
  // ****************************************************************
  // two stages per bit; metastability settles in the first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
    end
    else
    begin
      meta_q <= sif.raw;  // [R16]
      sync_q <= meta_q;   // [R16]
    end
  end
  assign sif.sync = sync_q;
endmodule : dcc_sync
`default_nettype wire

// file: hdl/dcc_top.sv
// digital control and status logic around two analog comparators
//
// Operation
// R1 - three-bit mode field in bits 2:0
// R2 - bit 7 read-only comparator 2 result
// R3 - bit 6 read-only comparator 1 result
// R4 - bits 5,4 invert comparator 2,1 outputs
// R5 - input switch bit 3 acts in mode 110
// R6 - reset clears results and flags, mode 111
// R7 - outputs drive pins and read back
// R8 - pin direction from port A direction register
// R9 - outputs unreliable while mode settles
// R10 - software masks interrupts during mode change
// R11 - inputs from port A analogs and reference
// R12 - change flag set on output change
// R13 - mismatch persists until control read; a control write also ends it
// R14 - mode 111 turns comparators off
// R15 - mode 110 reference on both plus inputs
// R16 - synchronise comparator outputs before use
`timescale 1ns/10ps
`default_nettype none
module dcc_top
(
  input  wire logic        clk_i,          // system clock, 125 MHz
  input  wire logic        rst_i,          // synchronous reset, high
  input  wire logic        wb_cyc_i,       // wishbone cycle
  input  wire logic        wb_stb_i,       // wishbone strobe
  input  wire logic        wb_we_i,        // wishbone write enable
  input  wire logic [3:0]  wb_adr_i,       // byte address
  input  wire logic [3:0]  wb_sel_i,       // byte selects
  input  wire logic [31:0] wb_dat_i,       // write data
  output logic      [31:0] wb_dat_o,       // read data
  output logic             wb_ack_o,       // acknowledge
  input  wire logic [1:0]  cmp_raw_i,      // analog comparator outputs, async
  output logic      [1:0]  cmp_enable_o,   // comparator power enables
  output logic      [2:0]  cmp_mode_o,     // mode to analog mux
  output logic             cmp_switch_o,   // inverting input select
  output logic             cmp_vref_sel_o, // internal reference on plus inputs
  output logic      [1:0]  cmp_pin_o,      // polarity-corrected pin outputs
  output logic      [1:0]  cmp_pin_oe_o,   // pin output enables
  output logic      [1:0]  cmp_valid_o,    // outputs reliable
  output logic      [5:0]  analog_sel_o,   // port A analogs in use
  output logic             irq_o           // level interrupt
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  dcc_sync_if                 sif ();          // synchroniser link
  logic                       ctl_inv2_q;      // cmp2_invert
  logic                       ctl_inv1_q;      // cmp1_invert
  logic                       ctl_switch_q;    // input_switch_select
  logic [2:0]                 ctl_mode_q;      // cmp_mode_select
  logic [1:0]                 result_q;        // polarity-corrected results
  logic [1:0]                 latched_q;       // result at last control read or write
  logic [1:0]                 status_q;        // sticky events
  logic [1:0]                 mask_q;          // interrupt mask
  logic [5:0]                 dir_q;           // porta_direction, 1 = input
  logic [31:0]                rdata_d;         // read mux
  logic [31:0]                rdata_q;         // registered read data
  logic                       ack_q;           // ack flop
  logic                       acc;             // access this cycle
  logic                       wr_en;           // write lane 0 taken
  logic                       rd_ctl;          // control register read
  logic                       rd_status;       // status register read
  logic [1:0]                 result_d;        // results after inversion
  logic                       mismatch;        // results differ from latch
  logic [1:0]                 set_ev;          // event sets
  logic                       mode_chg;        // mode field written new
  dcc_pkg::dcc_settle_type    settle_q;        // settle state
  logic [10:0]                settle_cnt_q;    // settle down-counter
  logic [7:0]                 ctl_view;        // control register image
  localparam logic [10:0] SETTLE_LOAD = 11'(dcc_pkg::SETTLE_CYCLES - 1);
  // ****************************************************************
  // synchroniser
  // ****************************************************************
  assign sif.raw = cmp_raw_i;
  dcc_sync u_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif)
  );
  // ****************************************************************
  // wishbone decode
  // ****************************************************************
  // one access per request; ack drops the cycle after it is given
  // reads are taken on the request edge; writes land at the edge where
  // the master samples ack, while it still holds address and data
  assign acc       = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_en     = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
  assign rd_ctl    = acc & ~wb_we_i & (wb_adr_i == dcc_pkg::ADDR_CONTROL);
  assign rd_status = acc & ~wb_we_i & (wb_adr_i == dcc_pkg::ADDR_STATUS);
  assign mode_chg  = wr_en & (wb_adr_i == dcc_pkg::ADDR_CONTROL)
                   & (wb_dat_i[dcc_pkg::MODE_MSB:0] != ctl_mode_q);
  // ****************************************************************
  // control register
  // ****************************************************************
  // writable fields; result bits ignore writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_inv2_q   <= dcc_pkg::CONTROL_RESET[dcc_pkg::BIT_CMP2_INVERT];   // [R6]
      ctl_inv1_q   <= dcc_pkg::CONTROL_RESET[dcc_pkg::BIT_CMP1_INVERT];   // [R6]
      ctl_switch_q <= dcc_pkg::CONTROL_RESET[dcc_pkg::BIT_INPUT_SWITCH];  // [R6]
      ctl_mode_q   <= dcc_pkg::CONTROL_RESET[dcc_pkg::MODE_MSB:0];        // [R6] [R14]
    end
    else if (wr_en && (wb_adr_i == dcc_pkg::ADDR_CONTROL))
    begin
      ctl_inv2_q   <= wb_dat_i[dcc_pkg::BIT_CMP2_INVERT];   // [R4]
      ctl_inv1_q   <= wb_dat_i[dcc_pkg::BIT_CMP1_INVERT];   // [R4]
      ctl_switch_q <= wb_dat_i[dcc_pkg::BIT_INPUT_SWITCH];  // [R5]
      ctl_mode_q   <= wb_dat_i[dcc_pkg::MODE_MSB:0];        // [R1]
    end
  end
  // ****************************************************************
  // mask and direction registers
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q <= dcc_pkg::MASK_RESET;
      dir_q  <= dcc_pkg::DIRECTION_RESET;
    end
    else if (wr_en)
    begin
      if (wb_adr_i == dcc_pkg::ADDR_MASK)
      begin
        mask_q <= wb_dat_i[1:0];
      end
      if (wb_adr_i == dcc_pkg::ADDR_DIRECTION)
      begin
        dir_q <= wb_dat_i[5:0];  // [R8]
      end
    end
  end
  // ****************************************************************
  // results with polarity
  // ****************************************************************
  // off comparators read zero so the change flag stays quiet
  always_comb
  begin
    result_d = sif.sync ^ {ctl_inv2_q, ctl_inv1_q};  // [R2] [R3] [R4]
    if (ctl_mode_q == dcc_pkg::MODE_OFF)
    begin
      result_d = 2'h0;  // [R14]
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      result_q <= 2'h0;  // [R6]
    end
    else
    begin
      result_q <= result_d;  // [R16]
    end
  end
  // ****************************************************************
  // change detection
  // ****************************************************************
  // latch takes the result at each control read or write; either ends the mismatch
  assign mismatch = (result_q != latched_q);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latched_q <= 2'h0;
    end
    else if (rd_ctl || (wr_en && (wb_adr_i == dcc_pkg::ADDR_CONTROL)))
    begin
      latched_q <= result_q;  // [R13]
    end
  end
  // ****************************************************************
  // settle timer
  // ****************************************************************
  // outputs held invalid for the mode change delay
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      settle_q     <= dcc_pkg::DCC_IDLE;
      settle_cnt_q <= 11'h000;
    end
    else
    begin
      case (settle_q)
        dcc_pkg::DCC_IDLE:
        begin
          if (mode_chg)
          begin
            settle_q     <= dcc_pkg::DCC_SETTLE;  // [R9]
            settle_cnt_q <= SETTLE_LOAD;
          end
        end
        dcc_pkg::DCC_SETTLE:
        begin
          if (mode_chg)
          begin
            settle_cnt_q <= SETTLE_LOAD;  // restart on a further change
          end
          else if (settle_cnt_q == 11'h000)
          begin
            settle_q <= dcc_pkg::DCC_IDLE;
          end
          else
          begin
            settle_cnt_q <= settle_cnt_q - 11'h001;
          end
        end
        default:
        begin
          settle_q <= dcc_pkg::DCC_IDLE;
        end
      endcase
    end
  end
  // ****************************************************************
  // sticky status
  // ****************************************************************
  // set wins over the read clear
  assign set_ev[dcc_pkg::BIT_CHANGE]   = mismatch;  // [R12] [R13]
  assign set_ev[dcc_pkg::BIT_SETTLING] = (settle_q == dcc_pkg::DCC_SETTLE) &&
                                         (settle_cnt_q == 11'h000) && !mode_chg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_q <= dcc_pkg::STATUS_RESET;  // [R6]
    end
    else if (rd_status)
    begin
      status_q <= set_ev;
    end
    else
    begin
      status_q <= status_q | set_ev;  // [R12]
    end
  end
  // ****************************************************************
  // read data and ack
  // ****************************************************************
  assign ctl_view = {result_q, ctl_inv2_q, ctl_inv1_q, ctl_switch_q, ctl_mode_q};  // [R7]
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (wb_adr_i)
      dcc_pkg::ADDR_CONTROL:   rdata_d = {24'h00_0000, ctl_view};      // [R2] [R3]
      dcc_pkg::ADDR_STATUS:    rdata_d = {30'h0000_0000, status_q};
      dcc_pkg::ADDR_MASK:      rdata_d = {30'h0000_0000, mask_q};
      dcc_pkg::ADDR_DIRECTION: rdata_d = {26'h000_0000, dir_q};
      default:                 rdata_d = 32'h0000_0000;  // unmapped reads zero
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= acc;
      rdata_q <= rdata_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  // ****************************************************************
  // analog control and pins
  // ****************************************************************
  // pins carry the registered results; direction comes only from dir_q
  assign cmp_mode_o     = ctl_mode_q;                                     // [R1]
  assign cmp_enable_o   = (ctl_mode_q == dcc_pkg::MODE_OFF) ? 2'h0 : 2'h3; // [R14]
  assign cmp_switch_o   = (ctl_mode_q == dcc_pkg::MODE_MUX4) & ctl_switch_q; // [R5]
  assign cmp_vref_sel_o = (ctl_mode_q == dcc_pkg::MODE_MUX4);              // [R15]
  assign analog_sel_o   = (ctl_mode_q == dcc_pkg::MODE_OFF) ? 6'h00 : 6'h3F; // [R11]
  assign cmp_pin_o      = result_q;                                       // [R7]
  assign cmp_pin_oe_o   = {~dir_q[5], ~dir_q[4]};                         // [R8]
  assign cmp_valid_o    = (settle_q == dcc_pkg::DCC_IDLE) ? 2'h3 : 2'h0;   // [R9]
  assign irq_o          = |(status_q & mask_q);                           // [R10]
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_reset_mode_off: assert property (@(posedge clk_i) $past(rst_i) |-> (ctl_mode_q == 3'h7)) // [R6]
    else $error("mode not 111 after reset");
  a_result_polarity: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (ctl_mode_q != 3'h7) |=> result_q[0] == ($past(sif.sync[0]) ^ $past(ctl_inv1_q)))
    else $error("cmp1 result polarity wrong");
  a_result2_polarity: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (ctl_mode_q != 3'h7) |=> result_q[1] == ($past(sif.sync[1]) ^ $past(ctl_inv2_q)))
    else $error("cmp2 result polarity wrong");
  a_change_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    mismatch |=> status_q[0])
    else $error("change flag not set on mismatch");
  a_read_ends_mismatch: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    rd_ctl && $stable(result_q) ##1 $stable(result_q) |-> !mismatch)
    else $error("control read did not end mismatch");
  a_off_disables: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    (ctl_mode_q == 3'h7) |-> (cmp_enable_o == 2'h0) && (analog_sel_o == 6'h00))
    else $error("comparators on in mode 111");
  a_switch_gated: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    cmp_switch_o |-> (ctl_mode_q == 3'h6) && ctl_switch_q && cmp_vref_sel_o)
    else $error("input switch outside mode 110");
  a_settle_invalid: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    mode_chg |=> (cmp_valid_o == 2'h0) [*8])
    else $error("outputs valid during settle");
  a_pin_direction: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    $rose(dir_q[4]) |-> !cmp_pin_oe_o[0])
    else $error("pin enable ignores direction");
  a_pin_follows: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (ctl_mode_q != 3'h7) |=> cmp_pin_o == ($past(sif.sync) ^ {$past(ctl_inv2_q), $past(ctl_inv1_q)}))
    else $error("pin does not follow comparator");
endmodule : dcc_top
`default_nettype wire

// file: sim/tb_top.sv
// self-checking testbench for the dual comparator control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic        clk_i;           // 125 MHz system clock
  logic        rst_i;           // synchronous reset
  logic        wb_cyc_i;        // bus cycle
  logic        wb_stb_i;        // bus strobe
  logic        wb_we_i;         // write enable
  logic [3:0]  wb_adr_i;        // byte address
  logic [3:0]  wb_sel_i;        // byte selects
  logic [31:0] wb_dat_i;        // write data
  logic [31:0] wb_dat_o;        // read data
  logic        wb_ack_o;        // acknowledge
  logic [1:0]  cmp_raw_i;       // comparator outputs, [1]=cmp2
  logic [1:0]  cmp_enable_o;    // power enables
  logic [2:0]  cmp_mode_o;      // mode to mux
  logic        cmp_switch_o;    // inverting input select
  logic        cmp_vref_sel_o;  // reference on plus inputs
  logic [1:0]  cmp_pin_o;       // pin outputs
  logic [1:0]  cmp_pin_oe_o;    // pin enables
  logic [1:0]  cmp_valid_o;     // outputs reliable
  logic [5:0]  analog_sel_o;    // analogs in use
  logic        irq_o;           // level interrupt
  int          err_count;       // mismatches seen
  int          samples_checked; // comparisons made
  logic [31:0] q;               // last read data
  dcc_top i_dcc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_raw_i(cmp_raw_i), .cmp_enable_o(cmp_enable_o),
    .cmp_mode_o(cmp_mode_o), .cmp_switch_o(cmp_switch_o), .cmp_vref_sel_o(cmp_vref_sel_o),
    .cmp_pin_o(cmp_pin_o), .cmp_pin_oe_o(cmp_pin_oe_o), .cmp_valid_o(cmp_valid_o),
    .analog_sel_o(analog_sel_o), .irq_o(irq_o));
  // ****************************************************************
  // clock, watchdog and verdict
  // ****************************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // tests take about 1450 cycles; over ten times that means a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run();
  end
  task complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ****************************************************************
  // classic bus cycle: hold until ack sampled, then one idle cycle
  // ****************************************************************
  task automatic wb_cycle(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                          output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    wb_cycle(a, 1'b1, d, 4'hF, q);
  endtask
  task rd(input logic [3:0] a);
    wb_cycle(a, 1'b0, 32'h0, 4'hF, q);
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(q, e);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    err_count = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    cmp_raw_i = 2'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset state of registers and pins
    rdc(dcc_pkg::ADDR_CONTROL, 32'h07);
    rdc(dcc_pkg::ADDR_STATUS, 32'h0);
    rdc(dcc_pkg::ADDR_MASK, 32'h0);
    rdc(dcc_pkg::ADDR_DIRECTION, 32'h3F);
    chk(32'({cmp_enable_o, analog_sel_o, irq_o, cmp_valid_o}), 32'h00003);
    // every mode with the switch bit set
    for (int m = 0; m < 8; m++)
    begin
      wr(dcc_pkg::ADDR_CONTROL, 32'h08 | m);
      chk(32'(cmp_mode_o), m);
      chk(32'({cmp_switch_o, cmp_vref_sel_o}), (m == 6) ? 32'h3 : 32'h0);
      chk(32'({cmp_enable_o, analog_sel_o}), (m == 7) ? 32'h0 : 32'hFF);
    end
    rdc(dcc_pkg::ADDR_CONTROL, 32'h0F);
    // settle interval after a mode change
    wr(dcc_pkg::ADDR_CONTROL, 32'h00);
    repeat (dcc_pkg::SETTLE_CYCLES - 10) @(posedge clk_i);
    chk(32'(cmp_valid_o), 32'h0);
    repeat (20) @(posedge clk_i);
    chk(32'(cmp_valid_o), 32'h3);
    rdc(dcc_pkg::ADDR_STATUS, 32'h2);
    rdc(dcc_pkg::ADDR_STATUS, 32'h0);
    // results, polarity and pins; result bits ignore writes
    cmp_raw_i <= 2'b01;
    repeat (6) @(posedge clk_i);
    rdc(dcc_pkg::ADDR_CONTROL, 32'h40);
    chk(32'(cmp_pin_o), 32'h1);
    wr(dcc_pkg::ADDR_CONTROL, 32'hF0);
    repeat (6) @(posedge clk_i);
    rdc(dcc_pkg::ADDR_CONTROL, 32'hB0);
    chk(32'(cmp_pin_o), 32'h2);
    rd(dcc_pkg::ADDR_STATUS);
    chk(q & 32'h1, 32'h1);
    rdc(dcc_pkg::ADDR_STATUS, 32'h0);
    // interrupt raised, persisting mismatch, cleared
    wr(dcc_pkg::ADDR_MASK, 32'h1);
    chk(32'(irq_o), 32'h0);
    cmp_raw_i <= 2'b11;
    repeat (6) @(posedge clk_i);
    chk(32'(irq_o), 32'h1);
    rdc(dcc_pkg::ADDR_STATUS, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h1);
    rdc(dcc_pkg::ADDR_CONTROL, 32'h30);
    rdc(dcc_pkg::ADDR_STATUS, 32'h1);
    rdc(dcc_pkg::ADDR_STATUS, 32'h0);
    chk(32'(irq_o), 32'h0);
    // masked: flag still set, no interrupt
    wr(dcc_pkg::ADDR_MASK, 32'h0);
    cmp_raw_i <= 2'b10;
    repeat (6) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    rdc(dcc_pkg::ADDR_CONTROL, 32'h70);
    rdc(dcc_pkg::ADDR_STATUS, 32'h1);
    rdc(dcc_pkg::ADDR_STATUS, 32'h0);
    // pin direction from the direction register
    chk(32'(cmp_pin_oe_o), 32'h0);
    wr(dcc_pkg::ADDR_DIRECTION, 32'h0F);
    chk(32'(cmp_pin_oe_o), 32'h3);
    wr(dcc_pkg::ADDR_DIRECTION, 32'h20);
    chk(32'(cmp_pin_oe_o), 32'h1);
    rdc(dcc_pkg::ADDR_DIRECTION, 32'h20);
    // refused accesses
    wb_cycle(dcc_pkg::ADDR_MASK, 1'b1, 32'h3, 4'h2, q);
    rdc(dcc_pkg::ADDR_MASK, 32'h0);
    wr(dcc_pkg::ADDR_STATUS, 32'hFF);
    rdc(dcc_pkg::ADDR_STATUS, 32'h0);
    wr(4'h2, 32'hFF);
    rdc(4'h2, 32'h0);
    // off mode forces results low and powers down
    wr(dcc_pkg::ADDR_CONTROL, 32'h37);
    repeat (6) @(posedge clk_i);
    rdc(dcc_pkg::ADDR_CONTROL, 32'h37);
    chk(32'({cmp_pin_o, cmp_enable_o, analog_sel_o}), 32'h0);
    // second reset in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(dcc_pkg::ADDR_CONTROL, 32'h07);
    rdc(dcc_pkg::ADDR_DIRECTION, 32'h3F);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
